// >>> logic/periodic_wakeup_counter.sv
// Purpose: 8-bit periodic wake-up counter with selectable source and prescaler
// Assumes: Source clocks and mode inputs are synchronous levels sampled on clk
// Notes: APB slave answers with no wait states; irq doubles as the wake request
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "periodic_wakeup_counter_consts.svh"

module periodic_wakeup_counter
#(
  parameter int DIV_W = `PWC_DIV_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire periodic_wakeup_counter_pkg::apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lpoClk,
  input wire logic extRefClk,
  input wire logic intRefClk,
  input wire logic debugHalt,
  input wire logic deepStop,
  output logic irq
);
  import periodic_wakeup_counter_pkg::*;

  localparam logic [16*`PWC_DIV_W-1:0] DIV_LO = `PWC_DIV_TBL_LO;
  localparam logic [16*`PWC_DIV_W-1:0] DIV_HI = `PWC_DIV_TBL_HI;

  // A narrower prescaler would wrap before the largest divisor is reached
  if (DIV_W < `PWC_DIV_W)
  begin : g_div_w_check
    $error("DIV_W too narrow for the largest divisor");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  periodic_ctrl_status_t ctrl;
  logic [7:0] tickCount;
  logic [7:0] tickLimit;
  logic [DIV_W-1:0] preCount;
  logic [2:0] srcPrev;

  logic setup;
  logic access;
  logic wrCtrl;
  logic wrLimit;
  logic cfgChange;
  logic clearCount;
  logic [2:0] srcLevel;
  logic [2:0] srcRise;
  logic srcEdge;
  logic [`PWC_DIV_W-1:0] divisor;
  logic [DIV_W-1:0] divLast;
  logic run;
  logic tick;
  logic match;
  logic next_flag;
  logic next_ie;
  logic [7:0] next_rdata;
  logic next_err;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  always_comb
  begin
    setup = apb.psel & ~apb.penable;
    access = apb.psel & apb.penable & pready;
    wrCtrl = access & apb.pwrite & (apb.paddr == `PWC_OFS_CTRL);
    wrLimit = access & apb.pwrite & (apb.paddr == `PWC_OFS_LIMIT);
  end

  // Compared against the stored fields, so rewriting equal values does not restart
  // source or prescaler change
  always_comb
  begin
    cfgChange = wrCtrl &
      ((apb.pwdata[`PWC_SRC_HI:`PWC_SRC_LO] != ctrl.tick_source_select) |
       (apb.pwdata[`PWC_PS_HI:`PWC_PS_LO] != ctrl.tick_divider_select));
    clearCount = cfgChange | wrLimit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and prescaler

  // Only rising edges count, so a source that idles high gives no tick
  always_comb
  begin
    srcLevel = {intRefClk, extRefClk, lpoClk};
    srcRise = srcLevel & ~srcPrev;
  end

  always_comb
  begin
    unique case (ctrl.tick_source_select)
      2'h0:
        srcEdge = srcRise[0];
      2'h1:
        srcEdge = srcRise[1] & ~deepStop;
      2'h2:
        srcEdge = srcRise[2] & ~deepStop;
      2'h3:
        srcEdge = srcRise[2] & ~deepStop;
    endcase
  end

  always_comb
  begin
    if (ctrl.tick_source_select[0])
      divisor = DIV_HI[32'(ctrl.tick_divider_select)*`PWC_DIV_W +: `PWC_DIV_W];
    else
      divisor = DIV_LO[32'(ctrl.tick_divider_select)*`PWC_DIV_W +: `PWC_DIV_W];
    // Code zero wraps to all ones here; run keeps it from mattering
    divLast = DIV_W'(divisor) - DIV_W'(1);
  end

  always_comb
  begin
    run = (ctrl.tick_divider_select != `PWC_PS_OFF) & ~debugHalt;
    tick = run & srcEdge & (preCount == divLast);
  end

  always_comb
  begin
    match = tick & (tickCount == tickLimit);
  end

  // Edge history is kept per source so a source switch gives no false edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      srcPrev <= 3'h0;
    else
      srcPrev <= srcLevel;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      preCount <= '0;
    else if (clearCount)
      preCount <= '0;
    else if (run & srcEdge)
    begin
      if (preCount == divLast)
        preCount <= '0;
      else
        preCount <= preCount + DIV_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and limit

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tickCount <= `PWC_RST_COUNT;
    else if (clearCount)
      tickCount <= `PWC_RST_COUNT;
    else if (match)
      tickCount <= 8'h00;
    else if (tick)
      tickCount <= tickCount + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tickLimit <= `PWC_RST_LIMIT;
    else if (wrLimit)
      tickLimit <= apb.pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, flag and request

  always_comb
  begin
    next_flag = match |
      (ctrl.periodic_match_flag & ~(wrCtrl & apb.pwdata[`PWC_BIT_FLAG]));
    next_ie = wrCtrl ? apb.pwdata[`PWC_BIT_IE] : ctrl.periodic_irq_enable;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl.periodic_match_flag <= 1'b0;
      ctrl.tick_source_select <= `PWC_RST_SRC;
      ctrl.periodic_irq_enable <= 1'b0;
      ctrl.tick_divider_select <= `PWC_RST_PS;
    end
    else
    begin
      ctrl.periodic_match_flag <= next_flag;
      ctrl.periodic_irq_enable <= next_ie;
      if (wrCtrl)
      begin
        ctrl.tick_source_select <= apb.pwdata[`PWC_SRC_HI:`PWC_SRC_LO];
        ctrl.tick_divider_select <= apb.pwdata[`PWC_PS_HI:`PWC_PS_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= next_flag & next_ie;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: read data captured in the setup cycle, ready in the next

  // Unmapped offsets answer with an error and read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    next_err = 1'b0;
    unique case (apb.paddr)
      `PWC_OFS_CTRL:
        next_rdata = ctrl;
      `PWC_OFS_COUNT:
        next_rdata = tickCount;
      `PWC_OFS_LIMIT:
        next_rdata = tickLimit;
      default:
        next_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & next_err;
      // Held until the next setup so the master may take it late in the access
      if (setup)
        prdata <= {24'h000000, next_rdata};
    end
  end

endmodule

// >>> logic/periodic_wakeup_counter_consts.svh
// Purpose: Offsets, field positions, reset values and divisor tables of the wake-up counter
// Assumes: 32-bit APB, one aligned word per register
// Notes: Divisor tables pack sixteen 18-bit entries, entry 0 in the low bits; 0 means off
`ifndef PERIODIC_WAKEUP_COUNTER_CONSTS_SVH
`define PERIODIC_WAKEUP_COUNTER_CONSTS_SVH

`define PWC_OFS_CTRL 12'h000
`define PWC_OFS_COUNT 12'h004
`define PWC_OFS_LIMIT 12'h008

`define PWC_BIT_FLAG 7
`define PWC_SRC_HI 6
`define PWC_SRC_LO 5
`define PWC_BIT_IE 4
`define PWC_PS_HI 3
`define PWC_PS_LO 0

`define PWC_RST_SRC 2'h0
`define PWC_RST_PS 4'h0
`define PWC_RST_LIMIT 8'h00
`define PWC_RST_COUNT 8'h00

`define PWC_SRC_LPO 2'h0
`define PWC_SRC_EXT 2'h1

`define PWC_DIV_W 18
`define PWC_PS_OFF 4'h0

// Low clock-select bit = 0
`define PWC_DIV_TBL_LO {18'h003e8, 18'h001f4, 18'h00064, 18'h00010, 18'h0000a, 18'h00004, \
  18'h00002, 18'h00001, 18'h00400, 18'h00200, 18'h00100, 18'h00080, 18'h00040, 18'h00020, \
  18'h00008, 18'h00000}
// Low clock-select bit = 1
`define PWC_DIV_TBL_HI {18'h30d40, 18'h186a0, 18'h0c350, 18'h04e20, 18'h02710, 18'h01388, \
  18'h007d0, 18'h003e8, 18'h10000, 18'h08000, 18'h04000, 18'h02000, 18'h01000, 18'h00800, \
  18'h00400, 18'h00000}

`endif

// >>> logic/periodic_wakeup_counter_pkg.sv
// Purpose: Types shared by the wake-up counter and its bench
// Assumes: APB with 12-bit address, 32-bit data
// Notes: Constants live in the consts header
package periodic_wakeup_counter_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic periodic_match_flag;
    logic [1:0] tick_source_select;
    logic periodic_irq_enable;
    logic [3:0] tick_divider_select;
  } periodic_ctrl_status_t;

endpackage

// >>> tb/periodic_wakeup_counter_properties.sv
// Purpose: Port-level properties of the periodic wake-up counter
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the design
`timescale 1ns/100ps
`include "periodic_wakeup_counter_consts.svh"
module periodic_wakeup_counter_properties
#(
  parameter int DIV_W = 18
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire periodic_wakeup_counter_pkg::apb_req_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lpoClk,
  input wire logic extRefClk,
  input wire logic intRefClk,
  input wire logic debugHalt,
  input wire logic deepStop,
  input wire logic irq
);
  import periodic_wakeup_counter_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Until software writes anything the divider is off, so no request may appear
  logic wrote;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wrote <= 1'b0;
    else if (apb.psel && apb.pwrite)
      wrote <= 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  ready_after_setup_a: assert property (apb.psel && !apb.penable |=> pready)
    else $error("no pready after setup");
  ready_one_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  mapped_no_error_a: assert property (apb.psel && !apb.penable && apb.paddr <= 12'h008 &&
    apb.paddr[1:0] == 2'h0 |=> !pslverr) else $error("error on mapped address");
  unmapped_error_a: assert property (apb.psel && !apb.penable && apb.paddr > 12'h008
    |=> pslverr) else $error("no error on unmapped address");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  irq_disable_drop_a: assert property (apb.psel && apb.penable && pready && apb.pwrite &&
    apb.paddr == `PWC_OFS_CTRL && !apb.pwdata[4] |=> ##1 !irq) else $error("irq with enable off");
  halt_hold_irq_a: assert property ((debugHalt && !apb.psel)[*2] |=> !$rose(irq))
    else $error("irq rose while halted");
  quiet_no_irq_a: assert property (!wrote |-> !irq)
    else $error("irq before any write");
endmodule
bind periodic_wakeup_counter periodic_wakeup_counter_properties #(.DIV_W(DIV_W)) u_props (
  .clk(clk), .rst_n(rst_n), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lpoClk(lpoClk), .extRefClk(extRefClk), .intRefClk(intRefClk), .debugHalt(debugHalt),
  .deepStop(deepStop), .irq(irq));

// >>> tb/periodic_wakeup_counter_bench.sv
// Purpose: Self-checking bench for the periodic wake-up counter
// Assumes: Reference clocks are slow levels, one pulse spans two clk cycles
// Notes: Divisors run at full length; the longest is 1000 edges
`timescale 1ns/100ps
`include "periodic_wakeup_counter_consts.svh"
module periodic_wakeup_counter_bench;
  import periodic_wakeup_counter_pkg::*;
  localparam logic [11:0] CT = `PWC_OFS_CTRL;
  localparam logic [11:0] CN = `PWC_OFS_COUNT;
  localparam logic [11:0] LM = `PWC_OFS_LIMIT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb = '0;
  logic [2:0] refs = 3'h0;
  logic debugHalt = 1'b0;
  logic deepStop = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int num_errors = 0;
  int num_checks = 0;
  int divs[8] = '{1, 2, 4, 10, 16, 100, 500, 1000};
  always #20 clk = ~clk;
  periodic_wakeup_counter u_periodic_wakeup_counter (.clk(clk), .rst_n(rst_n), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lpoClk(refs[0]),
    .extRefClk(refs[1]), .intRefClk(refs[2]), .debugHalt(debugHalt), .deepStop(deepStop),
    .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle after release keeps two requests from landing in one time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    apb <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata[7:0];
    apb <= '0;
    @(posedge clk);
    if (n >= 20)
    begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n)
    begin
      refs <= m;
      @(posedge clk);
      refs <= 3'h0;
      @(posedge clk);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(CT, 8'h00);
    rd(CN, 8'h00);
    rd(LM, 8'h00);
    rd(12'h00c, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_match();
    wr(LM, 8'h02);
    wr(CT, 8'h18);
    pulse(3'h1, 2);
    rd(CN, 8'h02);
    rd(CT, 8'h18);
    pulse(3'h1, 1);
    rd(CN, 8'h00);
    rd(CT, 8'h98);
    chk({7'h0, irq}, 8'h01);
    wr(CT, 8'h18);
    rd(CT, 8'h98);
    pulse(3'h1, 1);
    wr(CT, 8'h98);
    rd(CT, 8'h18);
    rd(CN, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(CT, 8'h08);
    pulse(3'h1, 2);
    rd(CT, 8'h88);
    chk({7'h0, irq}, 8'h00);
    wr(CN, 8'h55);
    rd(CN, 8'h00);
    pulse(3'h1, 1);
    wr(LM, 8'h00);
    rd(CN, 8'h00);
    wr(CT, 8'h88);
    pulse(3'h1, 1);
    rd(CT, 8'h88);
    $display("match and flag done");
  endtask
  task automatic t_div();
    for (int i = 0; i < 8; i++)
    begin
      wr(LM, 8'hff);
      wr(CT, 8'(8 + i));
      pulse(3'h1, divs[i] - 1);
      rd(CN, 8'h00);
      pulse(3'h1, 1);
      rd(CN, 8'h01);
    end
    wr(CT, 8'h00);
    pulse(3'h1, 3);
    rd(CN, 8'h00);
    $display("divisors done");
  endtask
  task automatic t_src();
    // source is selected before it runs
    wr(CT, 8'h68);
    pulse(3'h4, 999);
    rd(CN, 8'h00);
    pulse(3'h4, 1);
    rd(CN, 8'h01);
    wr(CT, 8'h28);
    rd(CN, 8'h00);
    pulse(3'h5, 2);
    pulse(3'h2, 999);
    rd(CN, 8'h00);
    pulse(3'h2, 1);
    rd(CN, 8'h01);
    deepStop <= 1'b1;
    pulse(3'h2, 1000);
    rd(CN, 8'h01);
    wr(CT, 8'h08);
    pulse(3'h1, 1);
    rd(CN, 8'h01);
    deepStop <= 1'b0;
    debugHalt <= 1'b1;
    pulse(3'h1, 2);
    rd(CN, 8'h01);
    debugHalt <= 1'b0;
    pulse(3'h1, 1);
    rd(CN, 8'h02);
    $display("sources and halt done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_match();
    t_div();
    t_src();
    print_verdict();
  end
endmodule
